// ---- logic/psq_pkg.sv ----
package psq_pkg;
  // Notes on behaviour
  // RULE1 - Four non-overlapping phases form one cycle.
  // RULE2 - First phase increments and fetches; rest execute.
  // RULE3 - Fetch of next overlaps current execution.
  // RULE4 - Branches take two instruction cycles.
  // RULE5 - Counter advances by one unless transferring.
  // RULE6 - Jump, call, interrupt, reset load destination.
  // RULE7 - Taken skip discards prefetch, runs dummy cycle.
  // RULE8 - Counter is ten bits: two high, low byte.
  // RULE9 - Low byte write jumps within page, dummy.
  // RULE10 - Low byte readable and writable by software.
  // RULE11 - Hidden four-entry stack holds counter values.
  // RULE12 - Call or interrupt acknowledge pushes counter.
  // RULE13 - Return instructions pop and restore counter.
  // RULE14 - Reset points stack pointer at top.
  // RULE15 - Full stack defers interrupt until a pop.
  // RULE16 - Call on full stack loses oldest entry.
  // RULE17 - Eight-bit ALU writes result to chosen target.
  // RULE18 - ALU operations update the status flags.
  // RULE19 - ALU covers arithmetic, logic, rotate, step ops.
  // RULE20 - Wake-up waits 1024 fast or 2 slow clocks.
  // RULE21 - Reset loads counter with address zero.
  // RULE22 - Transfers load all ten counter bits together.

  // Program counter and data widths.
  localparam int PC_W = 10;
  localparam int DW   = 8;

  // Register byte addresses.
  localparam logic [7:0] ADDR_PCL  = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ACC  = 8'h0C;

  // Control and status field positions.
  localparam int CTRL_SLOW  = 0;
  localparam int CTRL_IE    = 1;
  localparam int STAT_PC    = 0;
  localparam int STAT_SP    = 10;
  localparam int STAT_HALT  = 13;
  localparam int STAT_IPEND = 14;
  localparam int STAT_C     = 15;
  localparam int STAT_AC    = 16;
  localparam int STAT_Z     = 17;

  // Vectors and wake-up counts in system clocks.
  localparam logic [9:0]  RESET_VEC     = 10'h000;
  localparam logic [9:0]  INT_VEC_DEF   = 10'h004;
  localparam int          WAKE_FAST_CYC = 1024;
  localparam int          WAKE_SLOW_CYC = 2;
  localparam logic [10:0] WAKE_FAST_LD  = 11'(WAKE_FAST_CYC - 1);
  localparam logic [10:0] WAKE_SLOW_LD  = 11'(WAKE_SLOW_CYC - 1);

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Decoded instruction classes.
  typedef enum logic [3:0] {
    OP_SEQ, OP_ALU, OP_JMP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN_OP, OP_SKIP, OP_PCLW, OP_HALT
  } psq_kind_t;

  // ALU functions.
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_DAA, ALU_AND, ALU_OR, ALU_XOR,
    ALU_CPL, ALU_RR, ALU_RRC, ALU_RL, ALU_RLC, ALU_INC, ALU_DEC
  } psq_alu_t;

  // One decoded instruction.
  typedef struct packed {
    psq_kind_t  kind;
    psq_alu_t   alu;
    logic       to_mem;
    logic       cond;
    logic [9:0] target;
    logic [7:0] operand;
  } psq_op_t;

  // AXI4-Lite master to slave.
  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } psq_axi_req_t;

  // AXI4-Lite slave to master.
  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } psq_axi_rsp_t;
endpackage

// ---- logic/psq_core.sv ----
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module psq_core
  import psq_pkg::*;
#(
  parameter int         STACK_DEPTH = 4,          // Return stack entries.
  parameter logic [9:0] INT_VEC     = INT_VEC_DEF // Interrupt entry address.
)
(
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // Register bus.
  input  wire psq_axi_req_t axi_req_in,
  output psq_axi_rsp_t      axi_rsp_out,
  // Program memory fetch and decoded instruction.
  output logic [9:0]        fetch_addr_out,
  output logic              fetch_en_out,
  input  wire psq_op_t      op_in,
  // Phases, data result and events.
  output logic [3:0]        phase_out,
  output logic              dummy_out,
  output logic              mem_wr_out,
  output logic [7:0]        mem_data_out,
  input  wire logic         irq_in,
  output logic              irq_ack_out,
  input  wire logic         wake_in,
  output logic              halted_out
);

  // The stack pointer field is three bits wide.
  if (STACK_DEPTH < 2 || STACK_DEPTH > 7)
  begin : g_chk
    $error("STACK_DEPTH must lie between 2 and 7.");
  end

  // Run state of the sequencer.
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE} psq_st_t;

  // Sequencer state.
  psq_st_t      st_q, st_d; // Run, halt or wake-up.
  logic [1:0]   phase_q, phase_d; // Current phase index.
  logic [3:0]   ph_q, ph_d; // One-hot phase output.
  logic [9:0]   pc_q, pc_d; // Program counter.
  logic [9:0]   fa_q, fa_d; // Fetch address.
  logic         fen_q, fen_d; // Fetch strobe.
  logic         flush_q, flush_d; // Next execute is a dummy.
  logic         dum_q, dum_d; // Current cycle is a dummy.
  logic [9:0]   stk_q [STACK_DEPTH]; // Return stack, entry 0 newest.
  logic [9:0]   stk_d [STACK_DEPTH]; // Next stack contents.
  logic [2:0]   sp_q, sp_d; // Entries in use.
  logic [7:0]   acc_q, acc_d; // Accumulator.
  logic         c_q, c_d; // Carry flag.
  logic         ac_q, ac_d; // Half carry flag.
  logic         z_q, z_d; // Zero flag.
  logic         mwr_q, mwr_d; // Memory result strobe.
  logic [7:0]   mdat_q, mdat_d; // Memory result data.
  logic         ipend_q, ipend_d; // Latched interrupt request.
  logic         iack_q, iack_d; // Interrupt acknowledge strobe.
  logic         ie_q, ie_d; // Interrupt enable.
  logic         slow_q, slow_d; // Slow oscillator selected.
  logic [10:0]  wcnt_q, wcnt_d; // Wake-up countdown.
  logic         pclp_q, pclp_d; // Pending bus write of low byte.
  logic [7:0]   pclv_q, pclv_d; // Value of that write.

  // Bus slave state.
  logic         awr_q, awr_d; // Write address ready.
  logic         wr_q, wr_d; // Write data ready.
  logic [7:0]   awa_q, awa_d; // Captured write address.
  logic [7:0]   wd_q, wd_d; // Captured write data.
  logic         ws_q, ws_d; // Captured lane 0 strobe.
  logic         bv_q, bv_d; // Write response valid.
  logic [1:0]   br_q, br_d; // Write response code.
  logic         arr_q, arr_d; // Read address ready.
  logic         rv_q, rv_d; // Read data valid.
  logic [31:0]  rd_q, rd_d; // Read data.
  logic [1:0]   rr_q, rr_d; // Read response code.
  logic         wr_pcl; // Bus writes the low byte.
  logic         wr_ctrl; // Bus writes control.
  logic [7:0]   wdat; // Data of the bus write.

  // ALU outputs.
  logic [7:0]   alu_res; // Result byte.
  logic         alu_c, alu_ac, alu_z; // Resulting flags.

  // The ALU works on the accumulator and the memory operand.
  always_comb
  begin
    logic [7:0] b;
    logic       cin;
    logic [8:0] s9;
    logic [4:0] h5;
    logic [8:0] d9;
    b     = 8'h00;
    cin   = 1'b0;
    s9    = 9'h000;
    h5    = 5'h00;
    d9    = 9'h000;
    alu_res = 8'h00;
    alu_c   = c_q;
    alu_ac  = ac_q;
    case (op_in.alu)
      // Add and subtract share one adder; subtraction adds the inverse.
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC:
      begin
        b   = (op_in.alu == ALU_SUB || op_in.alu == ALU_SBC) ? ~op_in.operand
                                                              : op_in.operand;
        cin = (op_in.alu == ALU_SUB) ? 1'b1 :
              (op_in.alu == ALU_ADD) ? 1'b0 : c_q;
        s9  = {1'b0, acc_q} + {1'b0, b} + {8'h00, cin};
        h5  = {1'b0, acc_q[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        alu_res = s9[7:0];
        alu_c   = s9[8]; // RULE18
        alu_ac  = h5[4];
      end
      // Decimal adjust corrects the accumulator after a BCD add.
      ALU_DAA:
      begin
        d9 = {1'b0, acc_q};
        if (acc_q[3:0] > 4'h9 || ac_q)
        begin
          d9 = d9 + 9'h006;
        end
        if (d9[7:4] > 4'h9 || c_q || d9[8])
        begin
          d9 = d9 + 9'h060;
        end
        alu_res = d9[7:0];
        alu_c   = c_q | d9[8];
      end
      ALU_AND: alu_res = acc_q & op_in.operand;
      ALU_OR:  alu_res = acc_q | op_in.operand;
      ALU_XOR: alu_res = acc_q ^ op_in.operand;
      ALU_CPL: alu_res = ~op_in.operand;
      // Rotations around the byte or through the carry.
      ALU_RR:  alu_res = {op_in.operand[0], op_in.operand[7:1]};
      ALU_RL:  alu_res = {op_in.operand[6:0], op_in.operand[7]};
      ALU_RRC:
      begin
        alu_res = {c_q, op_in.operand[7:1]};
        alu_c   = op_in.operand[0];
      end
      ALU_RLC:
      begin
        alu_res = {op_in.operand[6:0], c_q};
        alu_c   = op_in.operand[7];
      end
      ALU_INC: alu_res = op_in.operand + 8'h01;
      ALU_DEC: alu_res = op_in.operand - 8'h01;
      default: alu_res = 8'h00;
    endcase
    // Rotations leave the zero flag alone.
    case (op_in.alu)
      ALU_RR, ALU_RL, ALU_RRC, ALU_RLC: alu_z = z_q;
      default:                          alu_z = (alu_res == 8'h00);
    endcase
  end

  // Sequencer: phases, program counter, stack, interrupts and wake-up.
  always_comb
  begin
    logic       xfer;
    logic       push;
    logic       pop;
    logic [9:0] pushv;
    xfer    = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    // The return point is the prefetched address that a transfer discards.
    pushv   = fa_q;
    st_d    = st_q;
    phase_d = phase_q;
    ph_d    = ph_q;
    pc_d    = pc_q;
    fa_d    = fa_q;
    fen_d   = 1'b0;
    flush_d = flush_q;
    dum_d   = dum_q;
    stk_d   = stk_q;
    sp_d    = sp_q;
    acc_d   = acc_q;
    c_d     = c_q;
    ac_d    = ac_q;
    z_d     = z_q;
    mwr_d   = 1'b0;
    mdat_d  = mdat_q;
    iack_d  = 1'b0;
    ie_d    = ie_q;
    slow_d  = slow_q;
    wcnt_d  = wcnt_q;
    pclp_d  = pclp_q;
    pclv_d  = pclv_q;
    ipend_d = ipend_q;
    case (st_q)
      ST_RUN:
      begin
        // The phase counter wraps through four phases per cycle.
        phase_d = phase_q + 2'h1; // RULE1
        ph_d    = 4'(4'h1 << phase_d); // RULE1
        if (phase_q == 2'h3)
        begin
          // Entering the first phase: fetch, then step the counter.
          fa_d  = pc_q; // RULE2 RULE3
          fen_d = 1'b1; // RULE2
          pc_d  = pc_q + 10'h001; // RULE5
          dum_d = flush_q; // RULE7
        end
        else if (phase_q == 2'h2)
        begin
          // Entering the last phase: execute the decoded instruction.
          if (flush_q)
          begin
            flush_d = 1'b0; // RULE4 RULE7
          end
          else
          begin
            case (op_in.kind)
              OP_ALU:
              begin
                // The result goes to memory or the accumulator.
                if (op_in.to_mem)
                begin
                  mwr_d  = 1'b1; // RULE17
                  mdat_d = alu_res; // RULE17
                end
                else
                begin
                  acc_d = alu_res; // RULE17 RULE19
                end
                c_d  = alu_c; // RULE18
                ac_d = alu_ac; // RULE18
                z_d  = alu_z; // RULE18
              end
              OP_JMP:
              begin
                pc_d = op_in.target; // RULE6 RULE22
                xfer = 1'b1; // RULE4
              end
              OP_CALL:
              begin
                push = 1'b1; // RULE12
                pc_d = op_in.target; // RULE6 RULE22
                xfer = 1'b1; // RULE4
              end
              OP_RET, OP_INTERRUPT_RETURN_OP:
              begin
                pop  = 1'b1; // RULE13
                pc_d = stk_q[0]; // RULE13 RULE22
                xfer = 1'b1;
                if (op_in.kind == OP_INTERRUPT_RETURN_OP)
                begin
                  ie_d = 1'b1;
                end
              end
              OP_SKIP:
              begin
                xfer = op_in.cond; // RULE7
              end
              OP_PCLW:
              begin
                pc_d = {pc_q[9:8], op_in.operand}; // RULE9 RULE10
                xfer = 1'b1; // RULE9
              end
              OP_HALT:
              begin
                // Resume must start at a fetch, not re-execute the halt.
                st_d    = ST_HALT;
                phase_d = 2'h3;
              end
              default: xfer = 1'b0;
            endcase
            // A plain instruction may be followed by interrupt entry.
            if (!xfer && op_in.kind != OP_HALT)
            begin
              if (ipend_q && ie_q && sp_q < 3'(STACK_DEPTH))
              begin
                push    = 1'b1; // RULE12
                pc_d    = INT_VEC; // RULE6 RULE22
                xfer    = 1'b1;
                ie_d    = 1'b0;
                iack_d  = 1'b1; // RULE15
              end
              else if (pclp_q)
              begin
                pc_d   = {pc_q[9:8], pclv_q}; // RULE9 RULE10
                xfer   = 1'b1; // RULE9
                pclp_d = 1'b0;
              end
            end
            flush_d = xfer; // RULE4 RULE7
          end
        end
      end
      ST_HALT:
      begin
        // Halted until woken; the delay depends on the oscillator.
        ph_d = 4'h0;
        if (wake_in || irq_in)
        begin
          st_d   = ST_WAKE;
          wcnt_d = slow_q ? WAKE_SLOW_LD : WAKE_FAST_LD; // RULE20
        end
      end
      ST_WAKE:
      begin
        // Count the start-up period down, then resume at a fetch.
        if (wcnt_q == 11'h000)
        begin
          st_d = ST_RUN; // RULE20
        end
        else
        begin
          wcnt_d = wcnt_q - 11'h001; // RULE20
        end
      end
      default:
      begin
        st_d = ST_RUN;
      end
    endcase
    // Push shifts down so an overflow drops the oldest entry.
    if (push)
    begin
      for (int i = STACK_DEPTH - 1; i > 0; i--)
      begin
        stk_d[i] = stk_q[i-1]; // RULE16
      end
      stk_d[0] = pushv; // RULE11 RULE12
      sp_d = (sp_q == 3'(STACK_DEPTH)) ? sp_q : sp_q + 3'h1; // RULE16
    end
    else if (pop)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
      begin
        stk_d[i] = stk_q[i+1]; // RULE13
      end
      sp_d = (sp_q == 3'h0) ? sp_q : sp_q - 3'h1; // RULE13 RULE15
    end
    // Request latch: a new request wins over the acknowledge.
    if (iack_d)
    begin
      ipend_d = 1'b0;
    end
    if (irq_in)
    begin
      ipend_d = 1'b1; // RULE15
    end
    // Bus writes: a new low byte wins over its own application.
    if (wr_pcl)
    begin
      pclp_d = 1'b1; // RULE10
      pclv_d = wdat; // RULE10
    end
    if (wr_ctrl)
    begin
      slow_d = wdat[CTRL_SLOW];
      ie_d   = wdat[CTRL_IE];
    end
  end

  // Sequencer registers; reset starts at the reset vector.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q    <= ST_RUN;
      phase_q <= 2'h3;
      ph_q    <= 4'h8;
      pc_q    <= RESET_VEC; // RULE21 RULE6
      fa_q    <= RESET_VEC;
      fen_q   <= 1'b0;
      flush_q <= 1'b1;
      dum_q   <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stk_q[i] <= 10'h000;
      end
      sp_q    <= 3'h0; // RULE14
      acc_q   <= 8'h00;
      c_q     <= 1'b0;
      ac_q    <= 1'b0;
      z_q     <= 1'b0;
      mwr_q   <= 1'b0;
      mdat_q  <= 8'h00;
      ipend_q <= 1'b0;
      iack_q  <= 1'b0;
      ie_q    <= 1'b0;
      slow_q  <= 1'b0;
      wcnt_q  <= 11'h000;
      pclp_q  <= 1'b0;
      pclv_q  <= 8'h00;
    end
    else
    begin
      st_q    <= st_d;
      phase_q <= phase_d;
      ph_q    <= ph_d;
      pc_q    <= pc_d;
      fa_q    <= fa_d;
      fen_q   <= fen_d;
      flush_q <= flush_d;
      dum_q   <= dum_d;
      stk_q   <= stk_d;
      sp_q    <= sp_d;
      acc_q   <= acc_d;
      c_q     <= c_d;
      ac_q    <= ac_d;
      z_q     <= z_d;
      mwr_q   <= mwr_d;
      mdat_q  <= mdat_d;
      ipend_q <= ipend_d;
      iack_q  <= iack_d;
      ie_q    <= ie_d;
      slow_q  <= slow_d;
      wcnt_q  <= wcnt_d;
      pclp_q  <= pclp_d;
      pclv_q  <= pclv_d;
    end
  end

  // Bus slave: write address and data in either order, one read at a time.
  always_comb
  begin
    logic       aw_hs;
    logic       w_hs;
    logic       fire;
    logic [7:0] wa;
    aw_hs = axi_req_in.awvalid & awr_q;
    w_hs  = axi_req_in.wvalid & wr_q;
    fire  = (aw_hs | ~awr_q) & (w_hs | ~wr_q) & ~bv_q;
    wa    = awr_q ? axi_req_in.awaddr : awa_q;
    wdat  = wr_q ? axi_req_in.wdata[7:0] : wd_q;
    awa_d = aw_hs ? axi_req_in.awaddr : awa_q;
    wd_d  = w_hs ? axi_req_in.wdata[7:0] : wd_q;
    ws_d  = w_hs ? axi_req_in.wstrb[0] : ws_q;
    awr_d = awr_q & ~aw_hs;
    wr_d  = wr_q & ~w_hs;
    bv_d  = bv_q;
    br_d  = br_q;
    wr_pcl  = 1'b0;
    wr_ctrl = 1'b0;
    if (fire)
    begin
      // Only byte lane 0 carries register bits.
      bv_d    = 1'b1;
      br_d    = (wa == ADDR_PCL || wa == ADDR_CTRL || wa == ADDR_STAT ||
                 wa == ADDR_ACC) ? RESP_OKAY : RESP_DECERR;
      wr_pcl  = (wa == ADDR_PCL) & (wr_q ? axi_req_in.wstrb[0] : ws_q);
      wr_ctrl = (wa == ADDR_CTRL) & (wr_q ? axi_req_in.wstrb[0] : ws_q);
    end
    else if (bv_q && axi_req_in.bready)
    begin
      bv_d  = 1'b0;
      awr_d = 1'b1;
      wr_d  = 1'b1;
    end
    arr_d = arr_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (axi_req_in.arvalid && arr_q)
    begin
      // Registers read back the sequencer's live state.
      arr_d = 1'b0;
      rv_d  = 1'b1;
      rr_d  = RESP_OKAY;
      rd_d  = 32'h0000_0000;
      case (axi_req_in.araddr)
        ADDR_PCL:  rd_d[7:0] = pc_q[7:0]; // RULE10
        ADDR_CTRL:
        begin
          rd_d[CTRL_SLOW] = slow_q;
          rd_d[CTRL_IE]   = ie_q;
        end
        ADDR_STAT:
        begin
          rd_d[STAT_PC +: PC_W] = pc_q;
          rd_d[STAT_SP +: 3]    = sp_q;
          rd_d[STAT_HALT]       = (st_q != ST_RUN);
          rd_d[STAT_IPEND]      = ipend_q;
          rd_d[STAT_C]          = c_q;
          rd_d[STAT_AC]         = ac_q;
          rd_d[STAT_Z]          = z_q;
        end
        ADDR_ACC:  rd_d[DW-1:0] = acc_q;
        default:   rr_d = RESP_DECERR;
      endcase
    end
    else if (rv_q && axi_req_in.rready)
    begin
      rv_d  = 1'b0;
      arr_d = 1'b1;
    end
  end

  // Bus slave registers.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      awr_q <= 1'b1;
      wr_q  <= 1'b1;
      awa_q <= 8'h00;
      wd_q  <= 8'h00;
      ws_q  <= 1'b0;
      bv_q  <= 1'b0;
      br_q  <= RESP_OKAY;
      arr_q <= 1'b1;
      rv_q  <= 1'b0;
      rd_q  <= 32'h0000_0000;
      rr_q  <= RESP_OKAY;
    end
    else
    begin
      awr_q <= awr_d;
      wr_q  <= wr_d;
      awa_q <= awa_d;
      wd_q  <= wd_d;
      ws_q  <= ws_d;
      bv_q  <= bv_d;
      br_q  <= br_d;
      arr_q <= arr_d;
      rv_q  <= rv_d;
      rd_q  <= rd_d;
      rr_q  <= rr_d;
    end
  end

  // Every output but halted_out is a register; halted_out is decoded from st_q.
  assign axi_rsp_out    = '{awready: awr_q, wready: wr_q, bvalid: bv_q, bresp: br_q,
                            arready: arr_q, rvalid: rv_q, rdata: rd_q, rresp: rr_q};
  assign fetch_addr_out = fa_q;
  assign fetch_en_out   = fen_q;
  assign phase_out      = ph_q;
  assign dummy_out      = dum_q;
  assign mem_wr_out     = mwr_q;
  assign mem_data_out   = mdat_q;
  assign irq_ack_out    = iack_q;
  assign halted_out     = (st_q != ST_RUN);

endmodule

// ---- tb/psq_pmem.sv ----
`timescale 1ns/100ps
module psq_pmem
  import psq_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Fetch port.
  input  wire logic [9:0] fetch_addr_in,
  input  wire logic       fetch_en_in,
  output psq_op_t         op_out
);
  psq_op_t nxt_q; // Word fetched last, shown one cycle later.
  // Fixed program; every other word is a plain op.
  function automatic psq_op_t word(input logic [9:0] a);
    case (a)
      10'h000: return {OP_ALU, ALU_AND, 20'h00000};
      10'h001: return {OP_ALU, ALU_ADD, 20'h80005};
      10'h002: return {OP_CALL, 24'h001000};
      10'h010: return {OP_RET, 24'h000000};
      10'h003: return {OP_JMP, 24'h002000};
      10'h020: return {OP_SKIP, 24'h040000};
      10'h021: return {OP_JMP, 24'h03FF00};
      10'h022: return {OP_HALT, 24'h000000};
      default: return '0;
    endcase
  endfunction
  // The word changes only on a fetch, so it stands through T2 to T4.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      nxt_q  <= '0;
      op_out <= '0;
    end
    else if (fetch_en_in)
    begin
      op_out <= nxt_q;
      nxt_q  <= word(fetch_addr_in);
    end
  end
endmodule

// ---- tb/psq_core_checker.sv ----
`timescale 1ns/100ps
module psq_core_checker
  import psq_pkg::*;
(
  // Watched ports.
  input wire logic         clk_in,
  input wire logic         arst_n_in,
  input wire psq_axi_req_t axi_req_in,
  input wire psq_axi_rsp_t axi_rsp_out,
  input wire logic [9:0]   fetch_addr_out,
  input wire logic         fetch_en_out,
  input wire psq_op_t      op_in,
  input wire logic [3:0]   phase_out,
  input wire logic         dummy_out,
  input wire logic         mem_wr_out,
  input wire logic [7:0]   mem_data_out,
  input wire logic         irq_in,
  input wire logic         irq_ack_out,
  input wire logic         wake_in,
  input wire logic         halted_out
);
  logic [9:0] prev_q; // Address of the previous fetch.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prev_q <= '0;
    else if (fetch_en_out)
      prev_q <= fetch_addr_out;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_phase;
    phase_out inside {4'h1, 4'h2, 4'h4} |=> phase_out == 4'($past(phase_out) << 1);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order broken");
  property p_fetch;
    fetch_en_out |-> phase_out == 4'h1;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch outside T1");
  property p_fa;
    phase_out inside {4'h2, 4'h4, 4'h8} |-> $stable(fetch_addr_out);
  endproperty
  a_fa: assert property (p_fa) else $error("fetch address moved");
  property p_seq;
    fetch_en_out && !dummy_out |-> fetch_addr_out == prev_q + 10'h001;
  endproperty
  a_seq: assert property (p_seq) else $error("pc not advanced by one");
  property p_dummy;
    $rose(dummy_out) |-> dummy_out [*4] ##1 !dummy_out;
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle length");
  property p_memwr;
    mem_wr_out |-> phase_out == 4'h8 ##1 !mem_wr_out;
  endproperty
  a_memwr: assert property (p_memwr) else $error("result write timing");
  property p_bresp;
    axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid && axi_rsp_out.wready
      |=> axi_rsp_out.bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late");
  property p_rhold;
    axi_rsp_out.rvalid && !axi_req_in.rready |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_halt;
    halted_out && $past(halted_out) |-> !fetch_en_out;
  endproperty
  a_halt: assert property (p_halt) else $error("fetch while halted");
  c_dummy: cover property ($rose(dummy_out));
  c_memwr: cover property (mem_wr_out);
  c_wake: cover property ($fell(halted_out));
endmodule

// ---- tb/psq_core_tb_top.sv ----
`timescale 1ns/100ps
module psq_core_tb_top
  import psq_pkg::*;
;
  logic clk_in, arst_n_in, fen, dm, mw, irq, ack, wk, hl; // Bench nets.
  logic [9:0] fa; // Fetch address.
  logic [3:0] ph; // Phase.
  logic [7:0] md; // Result data.
  psq_axi_req_t req; // Bus requests.
  psq_axi_rsp_t rsp; // Bus answers.
  psq_op_t op; // Program word.
  int fails, checks; // Counters.
  logic [10:0] tr[$]; // Dummy flag and address at each T1.
  logic [7:0] wq[$]; // Result bytes.
  logic [31:0] q; // Read data.
  logic [1:0] r; // Response.
  logic [10:0] ex[12] = '{11'h400, 11'h001, 11'h002, 11'h003, 11'h410, 11'h011,
                          11'h403, 11'h004, 11'h420, 11'h021, 11'h422, 11'h023};
  always #10 clk_in = ~clk_in;
  psq_core u_psq_core (.clk_in(clk_in), .arst_n_in(arst_n_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .fetch_addr_out(fa), .fetch_en_out(fen), .op_in(op), .phase_out(ph),
    .dummy_out(dm), .mem_wr_out(mw), .mem_data_out(md), .irq_in(irq), .irq_ack_out(ack),
    .wake_in(wk), .halted_out(hl));
  psq_pmem u_psq_pmem (.clk_in(clk_in), .arst_n_in(arst_n_in), .fetch_addr_in(fa),
    .fetch_en_in(fen), .op_out(op));
  // Records fetches and result writes where they are settled.
  always @(negedge clk_in)
  begin
    if (ph === 4'h1) tr.push_back({dm, fa});
    if (mw === 1'b1) wq.push_back(md);
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Ends the run when a wait runs out.
  task automatic hang();
    fails++;
    stop_test();
  endtask
  // One register write or read; payload holds until each channel is taken.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic aw, wd, ar, b;
    int n;
    @(posedge clk_in);
    if (w) req <= '{1'b1, a, 1'b1, d, 4'hF, 1'b1, 1'b0, 8'h00, 1'b0};
    else req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    b = 1'b0;
    for (n = 0; !b; n++)
    begin
      if (n > 50) hang();
      @(negedge clk_in);
      aw = req.awvalid && rsp.awready;
      wd = req.wvalid && rsp.wready;
      ar = req.arvalid && rsp.arready;
      b = w ? req.bready && rsp.bvalid : req.rready && rsp.rvalid;
      q = rsp.rdata;
      r = w ? rsp.bresp : rsp.rresp;
      @(posedge clk_in);
      if (aw) req.awvalid <= 1'b0;
      if (wd) req.wvalid <= 1'b0;
      if (ar) req.arvalid <= 1'b0;
      if (b) {req.bready, req.rready} <= 2'b00;
    end
  endtask
  // Reset state, first fetch, stack pointer and an unmapped place.
  task automatic t_reset();
    @(negedge clk_in);
    chk(ph === 4'h8 && fa === RESET_VEC, "reset state");
    @(posedge clk_in) arst_n_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    chk(fen === 1'b1 && fa === RESET_VEC, "first fetch");
    bus(1'b0, ADDR_STAT, 32'h0);
    chk(r === RESP_OKAY && q[12:10] === 3'h0, "stack top");
    bus(1'b0, 8'h10, 32'h0);
    chk(r === RESP_DECERR && q === 32'h0, "unmapped read");
  endtask
  // Call, return, jump and taken skip seen as the fetch trace.
  task automatic t_trace();
    for (int n = 0; tr.size() < 12; n++)
    begin
      if (n > 400) hang();
      @(posedge clk_in);
    end
    for (int i = 0; i < 12; i++)
      chk(tr[i] === ex[i], "fetch trace");
    chk(wq.size() > 0 && wq[0] === 8'h05, "alu result");
  endtask
  // Halt, then wake from the fast clock and count the start-up wait.
  task automatic t_wake();
    int n;
    for (n = 0; hl !== 1'b1; n++)
    begin
      if (n > 100) hang();
      @(negedge clk_in);
    end
    @(posedge clk_in) wk <= 1'b1;
    @(posedge clk_in) wk <= 1'b0;
    for (n = 0; ph === 4'h0; n++)
    begin
      if (n > 1100) hang();
      @(negedge clk_in);
    end
    chk(n >= 1022 && n <= 1026, "wake-up wait");
  endtask
  // Low byte write jumps inside page zero with a dummy cycle.
  task automatic t_pcl();
    bus(1'b1, ADDR_PCL, 32'h40);
    chk(r === RESP_OKAY, "pcl write");
    for (int n = 0; !(fa === 10'h040 && ph === 4'h1); n++)
    begin
      if (n > 100) hang();
      @(negedge clk_in);
    end
    chk(dm === 1'b1, "pcl jump dummy");
  endtask
  // Main sequence.
  initial
  begin
    clk_in = 1'b0;
    arst_n_in = 1'b0;
    req = '0;
    wk = 1'b0;
    irq = 1'b0;
    fails = 0;
    checks = 0;
    repeat (12) @(posedge clk_in);
    t_reset();
    t_trace();
    t_wake();
    t_pcl();
    stop_test();
  end
endmodule
bind psq_core psq_core_checker u_psq_core_checker (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .fetch_addr_out(fetch_addr_out),
  .fetch_en_out(fetch_en_out), .op_in(op_in), .phase_out(phase_out), .dummy_out(dummy_out),
  .mem_wr_out(mem_wr_out), .mem_data_out(mem_data_out), .irq_in(irq_in),
  .irq_ack_out(irq_ack_out), .wake_in(wake_in), .halted_out(halted_out));
